//--- include/aec_params.svh
// constants for the externally clocked conversion sequencer
// assumes one include per compile unit; guarded against repeats
`ifndef AEC_PARAMS_SVH
`define AEC_PARAMS_SVH

// ==========================================================================
// sequence shape
`define AEC_WORD_BITS 16
`define AEC_CNT_BITS 5
`define AEC_LAST_CONV_CNT 5'h0F
`define AEC_LAST_SHIFT_CNT 5'h10
`define AEC_TRIAL_RESET 16'h8000

// ==========================================================================
// host pulse timing, ns, with derived link-clock counts
`define AEC_LINK_PERIOD_NS 80
`define AEC_PULSE_MIN_NS 100
`define AEC_PULSE_MAX_NS 700
`define AEC_PULSE_MIN_CYC ((`AEC_PULSE_MIN_NS + `AEC_LINK_PERIOD_NS - 1) / `AEC_LINK_PERIOD_NS)
`define AEC_PULSE_MAX_CYC (`AEC_PULSE_MAX_NS / `AEC_LINK_PERIOD_NS)

`endif

//--- include/aec_pkg.sv
// types for the externally clocked conversion sequencer
// assumes nothing beyond a SystemVerilog compile
package aec_pkg;
    // ======================================================================
    // sequencer phases
    typedef enum logic [1:0] {
        AEC_IDLE = 2'b00,
        AEC_CONV = 2'b01,
        AEC_SHIFT = 2'b10
    } aec_state_e;
endpackage

//--- design/aec_core.sv
// successive-approximation sequencer stepped by host pulses on start_n
// assumes start_n and comparator come from outside the link clock domain
//
// What this block and its host do
// R1: host runs the start pulse train slower than the internal step rate.
// R2: start line idles high; host pulses it low once per step.
// R3: host holds each low pulse between 100 ns and 700 ns.
// R4: a falling then rising edge replaces the internal step clock.
// R5: conversion word is complete after the sixteenth pulse.
// R6: serial result is fully shifted out by the seventeenth pulse.
// R7: status goes high after the first pulse of a sequence.
// R8: status returns low after the seventeenth pulse.
// R9: host stops after seventeen pulses or on status falling.
`timescale 1ns/1ps
`default_nettype none
`include "aec_params.svh"

module aec_core (
    input wire logic sys_clk_in, // system clock, 100 MHz
    input wire logic rstn_in, // async reset, active low
    input wire logic link_clk_in, // link-side clock
    input wire logic start_n_in, // conversion start pulses, active low
    input wire logic comp_in, // comparator: sample at or above trial level
    output logic [15:0] dac_out, // trial word to the internal dac
    output logic status_out, // link-side busy status
    output logic ser_data_out, // serial result bit, msb first
    output logic busy_out, // busy, system domain
    output logic [15:0] result_out, // last finished word, system domain
    output logic result_valid_out // one-cycle pulse on new result
);
    // ======================================================================
    // helpers
    function automatic logic [15:0] aec_bit(input logic [4:0] idx);
        aec_bit = 16'h0001 << idx[3:0];
    endfunction

    // ======================================================================
    // link reset: async assert, release synced to the link clock
    logic lrst_s1_reg;
    logic lrstn_reg;
    always_ff @(posedge link_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lrst_s1_reg <= 1'b0;
            lrstn_reg <= 1'b0;
        end else begin
            lrst_s1_reg <= 1'b1;
            lrstn_reg <= lrst_s1_reg;
        end
    end

    // ======================================================================
    // pin synchronisers, a change counts once stages two and three agree
    logic [2:0] st_sync_reg;
    logic [2:0] cmp_sync_reg;
    logic start_q_reg;
    logic start_prev_reg;
    logic comp_q_reg;
    always_ff @(posedge link_clk_in or negedge lrstn_reg) begin
        if (!lrstn_reg) begin
            st_sync_reg <= 3'h7;
            cmp_sync_reg <= 3'h0;
            start_q_reg <= 1'b1;
            start_prev_reg <= 1'b1;
            comp_q_reg <= 1'b0;
        end else begin
            st_sync_reg <= {st_sync_reg[1:0], start_n_in};
            cmp_sync_reg <= {cmp_sync_reg[1:0], comp_in};
            start_prev_reg <= start_q_reg;
            if (st_sync_reg[1] == st_sync_reg[2]) begin
                start_q_reg <= st_sync_reg[2];
            end
            if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
                comp_q_reg <= cmp_sync_reg[2];
            end
        end
    end

    // rising edge after a low phase marks one external step
    logic step_w;
    assign step_w = start_q_reg & ~start_prev_reg; // R4

    // ======================================================================
    // step counter and phase, moves only on external steps
    aec_pkg::aec_state_e state_reg;
    logic [4:0] cnt_reg;
    always_ff @(posedge link_clk_in or negedge lrstn_reg) begin
        if (!lrstn_reg) begin
            state_reg <= aec_pkg::AEC_IDLE;
            cnt_reg <= 5'h00;
        end else if (step_w) begin // R4
            case (state_reg)
                aec_pkg::AEC_IDLE: begin
                    state_reg <= aec_pkg::AEC_CONV;
                    cnt_reg <= 5'h01;
                end
                aec_pkg::AEC_CONV: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == `AEC_LAST_CONV_CNT) begin
                        state_reg <= aec_pkg::AEC_SHIFT; // R5
                    end
                end
                aec_pkg::AEC_SHIFT: begin
                    state_reg <= aec_pkg::AEC_IDLE; // R6
                    cnt_reg <= 5'h00;
                end
                default: begin
                    state_reg <= aec_pkg::AEC_IDLE;
                    cnt_reg <= 5'h00;
                end
            endcase
        end
    end

    // ======================================================================
    // status: high after first step, low after seventeenth
    logic busy_reg;
    always_ff @(posedge link_clk_in or negedge lrstn_reg) begin
        if (!lrstn_reg) begin
            busy_reg <= 1'b0;
        end else if (step_w && state_reg == aec_pkg::AEC_IDLE) begin
            busy_reg <= 1'b1; // R7
        end else if (step_w && state_reg == aec_pkg::AEC_SHIFT) begin
            busy_reg <= 1'b0; // R8
        end
    end
    assign status_out = busy_reg;

    // ======================================================================
    // trial word: each of the first sixteen steps keeps or drops one bit, the first fifteen also try the next, the seventeenth presets it
    logic [15:0] trial_reg;
    logic [15:0] trial_next;
    logic [4:0] idx_w;
    logic resolving_w;
    assign idx_w = 5'h0F - cnt_reg;
    assign resolving_w = step_w && (state_reg != aec_pkg::AEC_SHIFT);
    always_comb begin
        trial_next = trial_reg;
        if (!comp_q_reg) begin
            trial_next = trial_next & ~aec_bit(idx_w);
        end
        if (idx_w != 5'h00) begin
            trial_next = trial_next | aec_bit(idx_w - 5'h01);
        end
    end

    logic [15:0] word_reg;
    logic done_tgl_reg;
    logic ser_reg;
    always_ff @(posedge link_clk_in or negedge lrstn_reg) begin
        if (!lrstn_reg) begin
            trial_reg <= `AEC_TRIAL_RESET;
            word_reg <= 16'h0000;
            done_tgl_reg <= 1'b0;
            ser_reg <= 1'b0;
        end else if (resolving_w) begin
            trial_reg <= trial_next;
            ser_reg <= comp_q_reg; // R6
            if (cnt_reg == `AEC_LAST_CONV_CNT) begin
                word_reg <= trial_next; // R5
                done_tgl_reg <= ~done_tgl_reg;
            end
        end else if (step_w) begin
            trial_reg <= `AEC_TRIAL_RESET; // ready for next sequence
        end
    end
    assign dac_out = trial_reg;
    assign ser_data_out = ser_reg;

    // ======================================================================
    // system side: busy level and done toggle each pass three flops,
    // a change counts once stages two and three agree
    logic [2:0] busy_sync_reg;
    logic busy_q_reg;
    logic [2:0] tgl_sync_reg;
    logic tgl_q_reg;
    logic tgl_new_w;
    logic [15:0] result_reg;
    logic valid_reg;
    // agreed toggle level differs from the one already taken
    assign tgl_new_w = (tgl_sync_reg[1] == tgl_sync_reg[2]) && (tgl_sync_reg[2] != tgl_q_reg);
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_sync_reg <= 3'h0;
            busy_q_reg <= 1'b0;
            tgl_sync_reg <= 3'h0;
            tgl_q_reg <= 1'b0;
            result_reg <= 16'h0000;
            valid_reg <= 1'b0;
        end else begin
            busy_sync_reg <= {busy_sync_reg[1:0], busy_reg};
            tgl_sync_reg <= {tgl_sync_reg[1:0], done_tgl_reg};
            if (busy_sync_reg[1] == busy_sync_reg[2]) begin
                busy_q_reg <= busy_sync_reg[2];
            end
            valid_reg <= tgl_new_w;
            if (tgl_new_w) begin
                tgl_q_reg <= tgl_sync_reg[2];
                result_reg <= word_reg; // word stable for many steps
            end
        end
    end
    assign busy_out = busy_q_reg;
    assign result_out = result_reg;
    assign result_valid_out = valid_reg;

    // ======================================================================
    // checks on the link side, and one on the system side
    sequence s_step_at(int n);
        step_w && cnt_reg == n;
    endsequence

    a_busy_rise: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R7
        (step_w && state_reg == aec_pkg::AEC_IDLE) |=> busy_reg && cnt_reg == 5'h01)
        else $error("status not high after first pulse");
    a_busy_fall: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R8
        s_step_at(16) |=> !busy_reg && state_reg == aec_pkg::AEC_IDLE)
        else $error("status not low after seventeenth pulse");
    a_busy_hold: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R8
        (busy_reg && cnt_reg != 5'h10) |=> busy_reg)
        else $error("status fell before seventeenth pulse");
    a_word_done: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R5
        s_step_at(15) |=> $changed(done_tgl_reg) && word_reg == $past(trial_next))
        else $error("word not complete after sixteenth pulse");
    a_no_early_done: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R5
        $changed(done_tgl_reg) |-> cnt_reg == 5'h10 && $past(step_w))
        else $error("word finished at wrong pulse");
    a_steps_only: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R4
        !step_w |=> $stable(cnt_reg) && $stable(trial_reg))
        else $error("sequencer moved without an external pulse");
    a_ser_bit: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R6
        resolving_w |=> ser_data_out == $past(comp_q_reg))
        else $error("serial bit differs from decision");
    a_count_range: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R6
        cnt_reg <= 5'h10 && (state_reg == aec_pkg::AEC_SHIFT) == (cnt_reg == 5'h10))
        else $error("step count out of range");
    a_trial_preset: assert property (@(posedge link_clk_in) disable iff (!lrstn_reg) // R5
        s_step_at(16) |=> dac_out == `AEC_TRIAL_RESET)
        else $error("trial word not preset for next sequence");
    a_valid_pulse: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R5
        result_valid_out |=> !result_valid_out)
        else $error("result valid longer than one cycle");
endmodule
`default_nettype wire

//--- bench/aec_host_model.sv
// host side model: start pulse generator and sample comparator
// assumes the bench calls pulse() once per step and loads sample_reg
`timescale 1ns/1ps
`default_nettype none

module aec_host_model (
    input wire logic link_clk_in, // link clock, times the pulses
    input wire logic [15:0] dac_in, // trial word from the converter
    output logic start_n_out, // start pulses, active low
    output logic comp_out // comparator decision
);
    logic [15:0] sample_reg; // held sample as a code

    // ==========================================================================
    // comparator: one while the sample is at or above the trial
    assign comp_out = (sample_reg >= dac_in);

    // start line idles high
    initial begin
        start_n_out = 1'b1;
        sample_reg = 16'h0000;
    end

    // one step: narrow low pulse, then a gap far longer than an internal step
    task automatic pulse(input int w);
        @(posedge link_clk_in);
        #1 start_n_out = 1'b0;
        repeat (w) @(posedge link_clk_in);
        #1 start_n_out = 1'b1;
        repeat (7) @(posedge link_clk_in);
    endtask
endmodule

`default_nettype wire

//--- bench/adc_external_clock_sequencing_bench.sv
// bench for the externally stepped conversion sequencer
// assumes aec_core and aec_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "aec_params.svh"

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module adc_external_clock_sequencing_bench;
    logic sys_clk_in, rstn_in, link_clk_in, start_n, comp, status, ser, busy, valid;
    logic [15:0] dac, result, s;
    logic [15:0] corners [4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
    int n_fail, samples_checked, n_valid, seed, i, w;

    aec_core dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
        .start_n_in(start_n), .comp_in(comp), .dac_out(dac), .status_out(status),
        .ser_data_out(ser), .busy_out(busy), .result_out(result), .result_valid_out(valid));
    aec_host_model host_u (.link_clk_in(link_clk_in), .dac_in(dac), .start_n_out(start_n),
        .comp_out(comp));

    // ==========================================================================
    // clocks: 10 ns system, 80 ns link with an odd phase
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #13;
        forever #40 link_clk_in = ~link_clk_in;
    end

    // counts result strobes
    initial n_valid = 0;
    always @(posedge sys_clk_in) begin
        if (valid === 1'b1) n_valid++;
    end

    // expected word from a bitwise trial search
    function automatic logic [15:0] sar_exp(input logic [15:0] v);
        logic [15:0] t;
        t = 16'h0000;
        for (int b = 15; b >= 0; b--) begin
            t[b] = 1'b1;
            if (v < t) t[b] = 1'b0;
        end
        return t;
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // one full sequence of seventeen steps, then the host stops
    task automatic check_conv(input logic [15:0] v, input int pw);
        logic [15:0] e;
        int v0;
        e = sar_exp(v);
        v0 = n_valid;
        #1 host_u.sample_reg = v;
        for (int k = 1; k <= 17; k++) begin
            host_u.pulse(pw);
            if (k <= 16) `CHK("status", 1'b1, status)
            if (k <= 16) `CHK("serial", e[16-k], ser)
            if (k == 1) `CHK("busy_high", 1'b1, busy)
            if (k == 15) `CHK("early_result", v0, n_valid)
        end
        `CHK("status_end", 1'b0, status)
        `CHK("busy_end", 1'b0, busy)
        `CHK("serial_end", e[0], ser)
        `CHK("dac_end", 16'h8000, dac)
        `CHK("result_count", v0 + 1, n_valid)
        `CHK("result", e, result)
    endtask

    // watchdog
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        n_fail++;
        $display("mismatch watchdog expected finish seen hang");
        test_done();
    end

    // main sequence: corners first, then random samples and widths
    initial begin
        seed = 32'haa59ca17;
        n_fail = 0;
        samples_checked = 0;
        rstn_in = 1'b0;
        repeat (16) @(posedge sys_clk_in);
        #1 rstn_in = 1'b1;
        repeat (8) @(posedge link_clk_in);
        #1;
        `CHK("dac_idle", 16'h8000, dac)
        `CHK("status_idle", 1'b0, status)
        `CHK("result_idle", 16'h0000, result)
        for (i = 0; i < 16; i++) begin
            s = (i < 4) ? corners[i] : 16'($random(seed));
            w = (i < 4) ? (i[0] ? `AEC_PULSE_MAX_CYC : `AEC_PULSE_MIN_CYC)
                : `AEC_PULSE_MIN_CYC
                + int'($unsigned($random(seed)) % (`AEC_PULSE_MAX_CYC - `AEC_PULSE_MIN_CYC + 1));
            check_conv(s, w);
            $display("test %0d done sample %h width %0d", i, s, w);
        end
        // cut a sequence short with a reset, then run a clean one
        s = 16'h5A5A;
        #1 host_u.sample_reg = s;
        for (i = 0; i < 5; i++) begin
            host_u.pulse(`AEC_PULSE_MIN_CYC);
        end
        #1 rstn_in = 1'b0;
        repeat (4) @(posedge link_clk_in);
        #1 rstn_in = 1'b1;
        repeat (8) @(posedge link_clk_in);
        #1;
        `CHK("dac_rst", 16'h8000, dac)
        `CHK("status_rst", 1'b0, status)
        `CHK("busy_rst", 1'b0, busy)
        `CHK("result_rst", 16'h0000, result)
        check_conv(s, `AEC_PULSE_MAX_CYC);
        $display("test reset done sample %h width %0d", s, `AEC_PULSE_MAX_CYC);
        test_done();
    end
endmodule

`default_nettype wire
